// ### hw/iat_map.svh
`ifndef IAT_MAP_SVH
`define IAT_MAP_SVH
`define IAT_OFF_HIGH 8'h24
`define IAT_OFF_LOW 8'h28
`define IAT_OFF_ALARM 8'h20
`define IAT_OFF_IRQ_STAT 8'h30
`define IAT_OFF_IRQ_EN 8'h34
`define IAT_OFF_IRQ_CLR 8'h38
`define IAT_RST_HIGH 32'h0000ffff
`define IAT_RST_LOW 32'h00000000
`define IAT_HYST_MSB 31
`define IAT_HYST_LSB 26
`define IAT_TH_MSB 15
`define IAT_BIT_OVW 0
`define IAT_BIT_TRP_H 4
`define IAT_BIT_TRP_L 5
`define IAT_BIT_ACT_H 10
`define IAT_BIT_ACT_L 11
`endif

// ### hw/iat_pkg.sv
package iat_pkg;
   typedef logic [17:0] iat_sample_type;
   typedef logic [5:0] iat_hyst_type;
   typedef enum logic [1:0] {IAT_IDLE, IAT_SETUP, IAT_ACCESS} iat_apb_state_type;
endpackage

// ### hw/iat_cmp_if.sv
`timescale 1ns/1ps
interface iat_cmp_if;
   logic [17:0] upper;
   logic [17:0] lower;
   logic [5:0] hyst;
   logic [17:0] sample;
   logic sample_valid;
   logic high_active;
   logic low_active;
   modport regs (output upper, lower, hyst, sample, sample_valid, input high_active, low_active);
   modport cmp (input upper, lower, hyst, sample, sample_valid, output high_active, low_active);
endinterface

// ### hw/iat_compare.sv
`timescale 1ns/1ps
module iat_compare (
   input wire logic clk,
   input wire logic rst_n,
   iat_cmp_if.cmp cmp
);
   logic [18:0] high_release;
   logic [18:0] low_release;

   // Wider sums avoid wrap at the range ends
   assign high_release = {1'b0, cmp.upper} - {13'h0000, cmp.hyst};
   assign low_release = {1'b0, cmp.lower} + {13'h0000, cmp.hyst};

   // RULE_10: high alarm hysteresis
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cmp.high_active <= 1'b0;
      end else if (cmp.sample_valid) begin
         if (cmp.sample > cmp.upper) begin
            cmp.high_active <= 1'b1;
         end else if (high_release[18] || {1'b0, cmp.sample} < high_release) begin
            cmp.high_active <= 1'b0;
         end
      end
   end

   // RULE_10: low alarm hysteresis
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cmp.low_active <= 1'b0;
      end else if (cmp.sample_valid) begin
         if (cmp.sample < cmp.lower) begin
            cmp.low_active <= 1'b1;
         end else if (!low_release[18] && {1'b0, cmp.sample} > low_release) begin
            cmp.low_active <= 1'b0;
         end
      end
   end
endmodule

// ### hw/iat_regs.sv
`timescale 1ns/1ps
`include "iat_map.svh"
// What this block does
// RULE_01: Hysteresis is high byte bits 31-26
// RULE_02: Host writes zero to hysteresis low bits
// RULE_03: High threshold is field plus two zeros
// RULE_04: Low threshold is field plus two zeros
// RULE_05: High register bits 23-16 read zero
// RULE_06: Low register upper half reads zero
// RULE_07: High register at bytes 24h-27h, little-endian
// RULE_08: Low register at bytes 28h-2Bh, little-endian
// RULE_09: Overall alarm ORs tripped flags
// RULE_10: Alarms trip past limits, release with hysteresis
module iat_regs (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Conversion results
   input wire logic [17:0] sample,
   input wire logic sample_valid,
   // Alarm outputs
   output logic overall_alarm_status,
   output logic irq
);
   iat_cmp_if cmp_bus ();
   iat_pkg::iat_apb_state_type state;
   logic [31:0] input_alarm_high_limit_and_hysteresis;
   logic [31:0] input_alarm_low_limit;
   logic [1:0] tripped;
   logic [1:0] irq_stat;
   logic [1:0] irq_en;
   logic [1:0] next_irq_stat;
   logic [1:0] rise;
   logic [1:0] active_q;
   logic wr_go;
   logic rd_go;
   logic hit;
   logic clr_tripped;
   logic [31:0] next_prdata;

   iat_compare u_compare (
      .clk(clk),
      .rst_n(rst_n),
      .cmp(cmp_bus)
   );

   // Slave answers one cycle after the access phase opens
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= iat_pkg::IAT_IDLE;
      end else begin
         case (state)
            iat_pkg::IAT_IDLE: begin
               if (psel && !penable) state <= iat_pkg::IAT_SETUP;
            end
            iat_pkg::IAT_SETUP: begin
               state <= iat_pkg::IAT_ACCESS;
            end
            iat_pkg::IAT_ACCESS: begin
               state <= (psel && !penable) ? iat_pkg::IAT_SETUP : iat_pkg::IAT_IDLE;
            end
            default: begin
               state <= iat_pkg::IAT_IDLE;
            end
         endcase
      end
   end

   assign pready = (state == iat_pkg::IAT_ACCESS);
   assign hit = (paddr == `IAT_OFF_HIGH) || (paddr == `IAT_OFF_LOW) ||
      (paddr == `IAT_OFF_ALARM) || (paddr == `IAT_OFF_IRQ_STAT) ||
      (paddr == `IAT_OFF_IRQ_EN) || (paddr == `IAT_OFF_IRQ_CLR);
   assign pslverr = pready && !hit;
   assign wr_go = psel && penable && pready && pwrite && hit;
   assign rd_go = psel && penable && !pwrite && (state == iat_pkg::IAT_SETUP);

   // RULE_07: byte lanes of high register
   // RULE_05: bits 23-16 never stored
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         input_alarm_high_limit_and_hysteresis <= `IAT_RST_HIGH;
      end else if (wr_go && paddr == `IAT_OFF_HIGH) begin
         if (pstrb[0]) input_alarm_high_limit_and_hysteresis[7:0] <= pwdata[7:0];
         if (pstrb[1]) input_alarm_high_limit_and_hysteresis[15:8] <= pwdata[15:8];
         if (pstrb[3]) input_alarm_high_limit_and_hysteresis[31:24] <= pwdata[31:24];
      end
   end

   // RULE_08: byte lanes of low register
   // RULE_06: upper half never stored
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         input_alarm_low_limit <= `IAT_RST_LOW;
      end else if (wr_go && paddr == `IAT_OFF_LOW) begin
         if (pstrb[0]) input_alarm_low_limit[7:0] <= pwdata[7:0];
         if (pstrb[1]) input_alarm_low_limit[15:8] <= pwdata[15:8];
      end
   end

   // RULE_03: high compare value
   assign cmp_bus.upper = {input_alarm_high_limit_and_hysteresis[`IAT_TH_MSB:0], 2'b00};
   // RULE_04: low compare value
   assign cmp_bus.lower = {input_alarm_low_limit[`IAT_TH_MSB:0], 2'b00};
   // RULE_01: hysteresis from bits 31-26
   // RULE_02: bits 25-24 are ignored
   assign cmp_bus.hyst =
      input_alarm_high_limit_and_hysteresis[`IAT_HYST_MSB:`IAT_HYST_LSB];
   assign cmp_bus.sample = sample;
   assign cmp_bus.sample_valid = sample_valid;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         active_q <= 2'b00;
      end else begin
         active_q <= {cmp_bus.low_active, cmp_bus.high_active};
      end
   end
   assign rise = {cmp_bus.low_active, cmp_bus.high_active} & ~active_q;
   // Reading the alarm word clears the tripped flags
   assign clr_tripped = psel && penable && pready && !pwrite && paddr == `IAT_OFF_ALARM;

   // Trip sets win over read-clear
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tripped <= 2'b00;
      end else begin
         tripped <= (clr_tripped ? 2'b00 : tripped) | rise;
      end
   end

   // RULE_09: overall alarm OR
   assign overall_alarm_status = |tripped;

   always_comb begin
      next_irq_stat = irq_stat;
      if (wr_go && paddr == `IAT_OFF_IRQ_CLR && pstrb[0]) begin
         next_irq_stat = irq_stat & ~pwdata[1:0];
      end
      next_irq_stat = next_irq_stat | rise;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_stat <= 2'b00;
      end else begin
         irq_stat <= next_irq_stat;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_en <= 2'b00;
      end else if (wr_go && paddr == `IAT_OFF_IRQ_EN && pstrb[0]) begin
         irq_en <= pwdata[1:0];
      end
   end

   assign irq = |(irq_stat & irq_en);

   always_comb begin
      next_prdata = 32'h00000000;
      case (paddr)
         `IAT_OFF_HIGH: next_prdata = input_alarm_high_limit_and_hysteresis;
         `IAT_OFF_LOW: next_prdata = input_alarm_low_limit;
         `IAT_OFF_ALARM: begin
            next_prdata[`IAT_BIT_OVW] = overall_alarm_status;
            next_prdata[`IAT_BIT_TRP_H] = tripped[0];
            next_prdata[`IAT_BIT_TRP_L] = tripped[1];
            next_prdata[`IAT_BIT_ACT_H] = cmp_bus.high_active;
            next_prdata[`IAT_BIT_ACT_L] = cmp_bus.low_active;
         end
         `IAT_OFF_IRQ_STAT: next_prdata[1:0] = irq_stat;
         `IAT_OFF_IRQ_EN: next_prdata[1:0] = irq_en;
         default: next_prdata = 32'h00000000;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata <= 32'h00000000;
      end else if (rd_go) begin
         prdata <= next_prdata;
      end
   end

   sequence write_high_s;
      wr_go && paddr == `IAT_OFF_HIGH && pstrb == 4'hf;
   endsequence

   high_write_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_07
      write_high_s |=> input_alarm_high_limit_and_hysteresis == {$past(pwdata[31:24]),
      8'h00, $past(pwdata[15:0])})
      else $error("high register write mismatch");
   high_resv_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_05
      input_alarm_high_limit_and_hysteresis[23:16] == 8'h00)
      else $error("high reserved bits set");
   low_resv_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_06
      input_alarm_low_limit[31:16] == 16'h0000)
      else $error("low reserved bits set");
   low_write_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_08
      wr_go && paddr == `IAT_OFF_LOW && pstrb[0] |=> input_alarm_low_limit[7:0] ==
      $past(pwdata[7:0]))
      else $error("low register write mismatch");
   upper_form_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_03
      cmp_bus.upper[1:0] == 2'b00 && cmp_bus.upper[17:2] ==
      input_alarm_high_limit_and_hysteresis[15:0])
      else $error("upper compare value wrong");
   lower_form_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_04
      cmp_bus.lower == {input_alarm_low_limit[15:0], 2'b00})
      else $error("lower compare value wrong");
   hyst_src_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_01
      cmp_bus.hyst == input_alarm_high_limit_and_hysteresis[31:26])
      else $error("hysteresis source wrong");
   overall_or_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_09
      $rose(cmp_bus.high_active) |=> overall_alarm_status)
      else $error("overall alarm missed trip");
   high_trip_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_10
      sample_valid && sample > cmp_bus.upper |=> cmp_bus.high_active)
      else $error("high alarm did not trip");
   low_trip_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_10
      sample_valid && sample < cmp_bus.lower |=> cmp_bus.low_active)
      else $error("low alarm did not trip");

   // Release checks use wider sums so a large hysteresis cannot wrap
   sequence high_clear_s;
      sample_valid && !(sample > cmp_bus.upper) &&
         ({1'b0, sample} + {13'h0000, cmp_bus.hyst} < {1'b0, cmp_bus.upper});
   endsequence

   sequence low_clear_s;
      sample_valid && !(sample < cmp_bus.lower) &&
         ({1'b0, sample} > {1'b0, cmp_bus.lower} + {13'h0000, cmp_bus.hyst});
   endsequence

   high_release_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_10
      high_clear_s |=> !cmp_bus.high_active)
      else $error("high alarm did not release");
   low_release_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_10
      low_clear_s |=> !cmp_bus.low_active)
      else $error("low alarm did not release");
   overall_low_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_09
      $rose(cmp_bus.low_active) |=> overall_alarm_status)
      else $error("overall alarm missed low trip");
   // A trip must survive a read-clear landing in the same cycle
   tripped_set_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_09
      rise != 2'b00 |=> (tripped & $past(rise)) == $past(rise))
      else $error("tripped flag lost its set");
   hyst_write_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_01
      wr_go && paddr == `IAT_OFF_HIGH && pstrb[3] |=> cmp_bus.hyst ==
      $past(pwdata[31:26]))
      else $error("hysteresis write mismatch");
   low_keep_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_08
      wr_go && paddr == `IAT_OFF_LOW && !pstrb[0] |=> input_alarm_low_limit[7:0] ==
      $past(input_alarm_low_limit[7:0]))
      else $error("low byte changed without strobe");
endmodule

// ### tb/iat_host.sv
`timescale 1ns/1ps
module iat_host (
   // Clock
   input wire logic clk,
   // APB master
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata,
   output logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h00000000;
      pstrb = 4'h0;
   end
   // Enter just after a rising edge; returns one edge after release
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
         input logic [3:0] s, output logic [31:0] rd, output logic err, output logic ok);
      ok = 1'b0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= (a == 8'h24) ? (d & 32'hfcffffff) : d;
      pstrb <= s;
      @(posedge clk);
      penable <= 1'b1;
      // Sample mid-cycle, where the combinational ready has settled
      for (int n = 0; n < 16 && !ok; n++) begin
         @(negedge clk);
         ok = (pready === 1'b1);
         if (ok) begin
            rd = prdata;
            err = pslverr;
         end
         @(posedge clk);
      end
      psel <= 1'b0;
      penable <= 1'b0;
      // Stale data must not look valid
      pwdata <= ~d;
      @(posedge clk);
   endtask
endmodule

// ### tb/iat_regs_tb.sv
`timescale 1ns/1ps
module iat_regs_tb;
   logic clk, rst_n, psel, penable, pwrite, pready, pslverr;
   logic sample_valid, overall_alarm_status, irq, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] pstrb;
   logic [17:0] sample;
   int miscompares = 0;
   int cmp_count = 0;
   iat_regs DUT (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .sample(sample), .sample_valid(sample_valid),
      .overall_alarm_status(overall_alarm_status), .irq(irq));
   iat_host host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict;
      if (miscompares == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
         input logic [3:0] s = 4'hf);
      logic ok;
      host.xfer(w, a, d, s, rd, err, ok);
      if (!ok) begin
         miscompares++;
         print_verdict();
      end
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      acc(1'b0, a, 32'h00000000);
      chk(rd, exp);
   endtask
   // Alarm outputs settle two edges after the qualifying pulse
   task automatic smp(input logic [17:0] v);
      sample <= v;
      sample_valid <= 1'b1;
      @(posedge clk);
      sample_valid <= 1'b0;
      repeat (3) @(posedge clk);
   endtask
   initial begin
      rst_n = 1'b0;
      sample = 18'h20000;
      sample_valid = 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rchk(8'h24, 32'h0000ffff);
      rchk(8'h28, 32'h00000000);
      acc(1'b1, 8'h24, 32'hfcff1234);
      rchk(8'h24, 32'hfc001234);
      acc(1'b1, 8'h28, 32'hffff5678);
      rchk(8'h28, 32'h00005678);
      acc(1'b1, 8'h24, 32'haaaaaaaa, 4'h1);
      rchk(8'h24, 32'hfc0012aa);
      acc(1'b1, 8'h28, 32'h0000ab00, 4'h2);
      rchk(8'h28, 32'h0000ab78);
      acc(1'b1, 8'h40, 32'h12345678);
      chk(32'(err), 32'h00000001);
      rchk(8'h40, 32'h00000000);
      acc(1'b1, 8'h24, 32'h04001000);
      acc(1'b1, 8'h28, 32'h00000100);
      acc(1'b1, 8'h34, 32'h00000003);
      smp(18'h04000);
      chk(32'(overall_alarm_status), 32'h00000000);
      smp(18'h04001);
      chk(32'({irq, overall_alarm_status}), 32'h00000003);
      rchk(8'h20, 32'h00000411);
      rchk(8'h20, 32'h00000400);
      chk(32'(overall_alarm_status), 32'h00000000);
      smp(18'h03fff);
      rchk(8'h20, 32'h00000400);
      smp(18'h03ffe);
      rchk(8'h20, 32'h00000000);
      rchk(8'h30, 32'h00000001);
      acc(1'b1, 8'h38, 32'h00000001);
      rchk(8'h30, 32'h00000000);
      chk(32'(irq), 32'h00000000);
      acc(1'b1, 8'h34, 32'h00000001);
      rchk(8'h34, 32'h00000001);
      smp(18'h00400);
      rchk(8'h20, 32'h00000000);
      smp(18'h003ff);
      chk(32'({irq, overall_alarm_status}), 32'h00000001);
      rchk(8'h20, 32'h00000821);
      rchk(8'h30, 32'h00000002);
      smp(18'h00401);
      rchk(8'h20, 32'h00000800);
      smp(18'h00402);
      rchk(8'h20, 32'h00000000);
      print_verdict();
   end
endmodule
